// file: rtl/ics_sequencer.sv
// ics_sequencer: instruction cycle timing, program counter, stack and flags
// assumes a decoder presents the class of the instruction at O_FETCH_ADDR
// during the fetch phase, and a data memory that reads combinationally
`timescale 1ns/100ps
`default_nettype none
`include "ics_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// - every instruction cycle lasts exactly four system clocks
// - most instructions one cycle; jump, call, returns, table read two
// - writing program counter low byte jumps there and adds a cycle
// - a taken skip adds one cycle; an untaken skip takes one
// - a test either goes on to the next instruction or skips it
// - moves: memory to accumulator, accumulator to memory, immediate
// - carry on addition above 255, borrow on subtraction below zero
// - increment and decrement by one, to memory or to accumulator
// - logic and complement set zero flag when result is zero
// - rotates move one bit; through-carry variants pass it via carry
// - call saves return address after itself; jump saves nothing
// - bit set and clear change one bit, keep all others
// - table read fetches a program memory byte into the data side
// - interrupt return sets global enable; plain return leaves it
module ics_sequencer #(
  parameter int ADDR_W      = 10,
  parameter int STACK_DEPTH = 4
) (
  // clock and reset
  input  wire logic              I_CLK_SYS,
  input  wire logic              I_RESET_N,
  // decoded instruction, valid during the fetch phase
  input  wire ics_pkg::ics_op_t  I_OP,
  input  wire logic              I_TO_ACC,
  input  wire logic              I_USE_IMM,
  input  wire logic              I_DEST_PCL,
  input  wire logic [7:0]        I_IMM,
  input  wire logic [2:0]        I_BIT_SEL,
  input  wire logic [7:0]        I_MEM_ADDR,
  input  wire logic [ADDR_W-1:0] I_TARGET,
  // read data from data memory and program memory table
  input  wire logic [7:0]        I_MEM_RDATA,
  input  wire logic [7:0]        I_TBL_DATA,
  // interrupt entry clears the global enable
  input  wire logic              I_GIE_CLEAR,
  // instruction fetch and timing
  output logic [ADDR_W-1:0]      O_FETCH_ADDR,
  output logic                   O_CYCLE_START,
  output logic                   O_DUMMY_CYCLE,
  // data memory
  output logic [7:0]             O_MEM_ADDR,
  output logic                   O_MEM_WE,
  output logic [7:0]             O_MEM_WDATA,
  // table read
  output logic [ADDR_W-1:0]      O_TBL_ADDR,
  output logic                   O_TBL_REQ,
  // core state
  output logic [7:0]             O_ACC,
  output logic                   O_CARRY,
  output logic                   O_ZERO,
  output logic                   O_GIE
);

  localparam int SP_W = $clog2(STACK_DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic logic is_two_cycle(input ics_pkg::ics_op_t op);
    return op inside {ics_pkg::ICS_JMP, ics_pkg::ICS_CALL, ics_pkg::ICS_RET,
                      ics_pkg::ICS_INTERRUPT_RETURN, ics_pkg::ICS_TBL};
  endfunction

  function automatic logic is_skip(input ics_pkg::ics_op_t op);
    return op inside {ics_pkg::ICS_SZ, ics_pkg::ICS_SZB, ics_pkg::ICS_SNZB,
                      ics_pkg::ICS_SIZ, ics_pkg::ICS_SDZ};
  endfunction

  // a plain zero test only moves data when it targets the accumulator
  function automatic logic has_result(input ics_pkg::ics_op_t op, input logic to_acc);
    return !(op inside {ics_pkg::ICS_NOP, ics_pkg::ICS_SZB, ics_pkg::ICS_SNZB,
                        ics_pkg::ICS_JMP, ics_pkg::ICS_CALL, ics_pkg::ICS_RET,
                        ics_pkg::ICS_INTERRUPT_RETURN, ics_pkg::ICS_TBL})
           && !(op == ics_pkg::ICS_SZ && !to_acc);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [1:0]        phase_reg;
  logic              dummy_reg;
  ics_pkg::ics_op_t  op_reg;
  logic              to_acc_reg;
  logic              use_imm_reg;
  logic              dest_pcl_reg;
  logic [7:0]        imm_reg;
  logic [2:0]        bit_reg;
  logic [7:0]        addr_reg;
  logic [ADDR_W-1:0] target_reg;
  logic [7:0]        m_reg;
  logic [ADDR_W-1:0] pc_reg;
  logic [7:0]        acc_reg;
  logic              carry_reg;
  logic              zero_reg;
  logic              gie_reg;
  logic              start_reg;
  logic [7:0]        mem_addr_reg;
  logic              mem_we_reg;
  logic [7:0]        wdata_reg;
  logic              tbl_req_reg;
  logic [ADDR_W-1:0] tbl_addr_reg;
  logic [SP_W-1:0]   sp_reg;
  logic [ADDR_W-1:0] stack_mem [STACK_DEPTH];

  ////////////////////////////////////////////////////////////////////////////
  // decode and next values
  logic [7:0] alu_res;
  logic       alu_cout;
  logic       alu_c_we;
  logic       alu_z_we;
  logic       alu_skip;

  wire              ph_exec     = (phase_reg == `ICS_PH_EXEC);
  wire              exec        = ph_exec && !dummy_reg;
  wire              latch_instr = (phase_reg == `ICS_PH_FETCH) && !dummy_reg;
  wire [7:0]        opnd        = use_imm_reg ? imm_reg : m_reg;
  wire              res_ok      = has_result(op_reg, to_acc_reg);
  wire              wr_pcl      = exec && res_ok && dest_pcl_reg;
  wire              wr_acc      = exec && res_ok && to_acc_reg && !dest_pcl_reg;
  wire              wr_mem      = exec && res_ok && !to_acc_reg && !dest_pcl_reg;
  wire              skip_taken  = exec && is_skip(op_reg) && alu_skip;
  wire              do_call     = exec && (op_reg == ics_pkg::ICS_CALL);
  wire              do_ret      = exec && (op_reg inside {ics_pkg::ICS_RET, ics_pkg::ICS_INTERRUPT_RETURN});
  wire              do_jump     = exec && (op_reg inside {ics_pkg::ICS_JMP, ics_pkg::ICS_CALL});
  wire              do_tbl      = exec && (op_reg == ics_pkg::ICS_TBL);
  wire              tbl_done    = ph_exec && dummy_reg && tbl_req_reg;
  wire              extra       = exec && (is_two_cycle(op_reg) || wr_pcl || skip_taken);
  wire [SP_W-1:0]   sp_top      = sp_reg - 1'b1;
  wire [ADDR_W-1:0] pc_inc      = pc_reg + 1'b1;
  wire [ADDR_W-1:0] pc_skip     = pc_reg + ADDR_W'(`ICS_SKIP_STEP);

  // a pcl write keeps the upper bits of the counter
  wire [ADDR_W-1:0] pc_next =
      !exec      ? pc_reg :
      do_jump    ? target_reg :
      do_ret     ? stack_mem[sp_top] :
      wr_pcl     ? {pc_reg[ADDR_W-1:8], alu_res} :
      skip_taken ? pc_skip :
                   pc_inc;

  // the spare cycle ends with the frame of four clocks that follows
  wire       dummy_next = ph_exec ? extra : dummy_reg;
  wire [1:0] phase_next = ph_exec ? `ICS_PH_FETCH : phase_reg + 2'h1;

  wire [7:0] acc_next =
      wr_acc                 ? alu_res :
      tbl_done && to_acc_reg ? I_TBL_DATA :
                               acc_reg;
  wire       mem_we_next = wr_mem || (tbl_done && !to_acc_reg);
  wire [7:0] wdata_next  = tbl_done ? I_TBL_DATA : alu_res;
  wire       carry_next  = (exec && alu_c_we) ? alu_cout : carry_reg;
  wire       zero_next   = (exec && alu_z_we) ? (alu_res == `ICS_BYTE_ZERO) : zero_reg;
  // the return sets the enable even when an entry clears it at the same edge
  wire       gie_next =
      (exec && op_reg == ics_pkg::ICS_INTERRUPT_RETURN) ? 1'b1 :
      I_GIE_CLEAR                          ? 1'b0 :
                                             gie_reg;
  wire [SP_W-1:0] sp_next = do_call ? sp_reg + 1'b1 : do_ret ? sp_top : sp_reg;

  ics_alu u_alu (
    .i_op      (op_reg),
    .i_acc     (acc_reg),
    .i_opnd    (opnd),
    .i_carry   (carry_reg),
    .i_bit_sel (bit_reg),
    .o_res     (alu_res),
    .o_carry   (alu_cout),
    .o_carry_we(alu_c_we),
    .o_zero_we (alu_z_we),
    .o_skip    (alu_skip)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencing registers
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      phase_reg <= `ICS_RST_PHASE;
      dummy_reg <= `ICS_RST_BIT;
      start_reg <= `ICS_RST_BIT;
      pc_reg    <= '0;
      sp_reg    <= '0;
    end else begin
      phase_reg <= phase_next;
      dummy_reg <= dummy_next;
      start_reg <= ph_exec;
      pc_reg    <= pc_next;
      sp_reg    <= sp_next;
    end
  end

  // a fetch in a spare cycle is discarded, so the instruction is held
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      op_reg       <= ics_pkg::ICS_NOP;
      to_acc_reg   <= `ICS_RST_BIT;
      use_imm_reg  <= `ICS_RST_BIT;
      dest_pcl_reg <= `ICS_RST_BIT;
      imm_reg      <= `ICS_RST_BYTE;
      bit_reg      <= '0;
      addr_reg     <= `ICS_RST_BYTE;
      target_reg   <= '0;
    end else if (latch_instr) begin
      op_reg       <= I_OP;
      to_acc_reg   <= I_TO_ACC;
      use_imm_reg  <= I_USE_IMM;
      dest_pcl_reg <= I_DEST_PCL;
      imm_reg      <= I_IMM;
      bit_reg      <= I_BIT_SEL;
      addr_reg     <= I_MEM_ADDR;
      target_reg   <= I_TARGET;
    end
  end

  // the address moves one phase late so a write-back pulse keeps its address
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      mem_addr_reg <= `ICS_RST_BYTE;
      m_reg        <= `ICS_RST_BYTE;
    end else begin
      if (phase_reg == `ICS_PH_ADDR && !dummy_reg)
        mem_addr_reg <= addr_reg;
      if (phase_reg == `ICS_PH_READ && !dummy_reg)
        m_reg <= I_MEM_RDATA;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      acc_reg      <= `ICS_RST_BYTE;
      carry_reg    <= `ICS_RST_BIT;
      zero_reg     <= `ICS_RST_BIT;
      gie_reg      <= `ICS_RST_BIT;
      mem_we_reg   <= `ICS_RST_BIT;
      wdata_reg    <= `ICS_RST_BYTE;
      tbl_req_reg  <= `ICS_RST_BIT;
      tbl_addr_reg <= '0;
    end else begin
      acc_reg     <= acc_next;
      carry_reg   <= carry_next;
      zero_reg    <= zero_next;
      gie_reg     <= gie_next;
      mem_we_reg  <= mem_we_next;
      wdata_reg   <= wdata_next;
      tbl_req_reg <= do_tbl || (tbl_req_reg && !tbl_done);
      if (do_tbl)
        tbl_addr_reg <= target_reg;
    end
  end

  // return stack wraps when full, as the counter only pushes what it holds
  always_ff @(posedge I_CLK_SYS) begin
    if (do_call)
      stack_mem[sp_reg] <= pc_inc;
  end

  assign O_FETCH_ADDR  = pc_reg;
  assign O_CYCLE_START = start_reg;
  assign O_DUMMY_CYCLE = dummy_reg;
  assign O_MEM_ADDR    = mem_addr_reg;
  assign O_MEM_WE      = mem_we_reg;
  assign O_MEM_WDATA   = wdata_reg;
  assign O_TBL_ADDR    = tbl_addr_reg;
  assign O_TBL_REQ     = tbl_req_reg;
  assign O_ACC         = acc_reg;
  assign O_CARRY       = carry_reg;
  assign O_ZERO        = zero_reg;
  assign O_GIE         = gie_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESET_N);

  wire [8:0] chk_add = {1'b0, acc_reg} + {1'b0, opnd};

  cycle_four_clocks_a: assert property (
    O_CYCLE_START |=> !O_CYCLE_START [*3] ##1 O_CYCLE_START)
    else $error("instruction cycle is not four clocks");
  single_cycle_a: assert property (
    exec && op_reg == ics_pkg::ICS_NOP |=> !O_DUMMY_CYCLE [*4])
    else $error("plain instruction took a spare cycle");
  branch_two_cycles_a: assert property (
    exec && op_reg == ics_pkg::ICS_JMP |=> O_DUMMY_CYCLE [*4] ##1 !O_DUMMY_CYCLE)
    else $error("jump did not take exactly two cycles");
  pcl_write_jump_a: assert property (
    wr_pcl |=> O_DUMMY_CYCLE && O_FETCH_ADDR[7:0] == $past(alu_res))
    else $error("low counter byte write did not jump with a spare cycle");
  skip_untaken_a: assert property (
    exec && is_skip(op_reg) && !alu_skip |=> !O_DUMMY_CYCLE && O_FETCH_ADDR == $past(pc_inc))
    else $error("untaken skip cost a spare cycle");
  skip_taken_pc_a: assert property (
    skip_taken |=> O_DUMMY_CYCLE && O_FETCH_ADDR == $past(pc_skip))
    else $error("taken skip did not pass over one instruction");
  move_imm_a: assert property (
    exec && op_reg == ics_pkg::ICS_MOV_I2A && use_imm_reg && wr_acc
    |=> O_ACC == $past(imm_reg))
    else $error("immediate move did not load the accumulator");
  add_carry_a: assert property (
    exec && op_reg == ics_pkg::ICS_ADD |=> O_CARRY == $past(chk_add[8]))
    else $error("addition carry wrong");
  inc_to_acc_a: assert property (
    exec && op_reg == ics_pkg::ICS_INC && wr_acc |=> O_ACC == $past(opnd) + 8'h01)
    else $error("increment to accumulator wrong");
  and_zero_a: assert property (
    exec && op_reg == ics_pkg::ICS_AND
    |=> O_ZERO == (($past(acc_reg) & $past(opnd)) == 8'h00))
    else $error("logic zero flag wrong");
  rotate_carry_a: assert property (
    exec && op_reg == ics_pkg::ICS_RRC |=> O_CARRY == $past(opnd[0]))
    else $error("right rotate through carry lost the low bit");
  call_return_a: assert property (
    do_call |=> stack_mem[$past(sp_reg)] == $past(pc_inc) && O_FETCH_ADDR == $past(target_reg))
    else $error("call did not save the following address");
  bit_set_a: assert property (
    exec && op_reg == ics_pkg::ICS_BSET && wr_mem
    |=> O_MEM_WE && O_MEM_WDATA == ($past(opnd) | (8'h01 << $past(bit_reg))))
    else $error("bit set changed other bits");
  table_write_a: assert property (
    do_tbl && !to_acc_reg |=> O_TBL_REQ [*4] ##1 (O_MEM_WE && O_MEM_WDATA == $past(I_TBL_DATA)))
    else $error("table byte not written back");
  interrupt_return_enable_a: assert property (
    exec && op_reg == ics_pkg::ICS_INTERRUPT_RETURN |=> O_GIE)
    else $error("interrupt return did not set the enable");
  ret_keeps_gie_a: assert property (
    exec && op_reg == ics_pkg::ICS_RET && !I_GIE_CLEAR |=> O_GIE == $past(O_GIE))
    else $error("plain return changed the enable");

  call_seen_c: cover property (do_call ##[4:400] (exec && op_reg == ics_pkg::ICS_RET));
  skip_seen_c: cover property (skip_taken);
  table_seen_c: cover property (tbl_done);

endmodule
`default_nettype wire

// file: pkg/ics_map.svh
// ics_map.svh: phase codes, reset values and timing counts of the sequencer
// assumes inclusion by bare name from rtl files; definitions only
`ifndef ICS_MAP_SVH
`define ICS_MAP_SVH

// instruction cycle timing
`define ICS_CLKS_PER_CYCLE 4
`define ICS_PH_FETCH       2'h0
`define ICS_PH_ADDR        2'h1
`define ICS_PH_READ        2'h2
`define ICS_PH_EXEC        2'h3

// reset values
`define ICS_RST_BYTE       8'h00
`define ICS_RST_BIT        1'b0
`define ICS_RST_PHASE      2'h0

// data path constants
`define ICS_BYTE_ZERO      8'h00
`define ICS_BYTE_ONE       8'h01
`define ICS_SKIP_STEP      2

`endif

// file: pkg/ics_pkg.sv
// ics_pkg: operation classes delivered by the instruction decoder
// assumes the decoder maps every opcode onto one of these classes
package ics_pkg;

  typedef enum logic [4:0] {
    ICS_NOP,
    ICS_MOV_M2A,
    ICS_MOV_A2M,
    ICS_MOV_I2A,
    ICS_ADD,
    ICS_ADC,
    ICS_SUB,
    ICS_SBC,
    ICS_INC,
    ICS_DEC,
    ICS_AND,
    ICS_OR,
    ICS_XOR,
    ICS_CPL,
    ICS_RR,
    ICS_RL,
    ICS_RRC,
    ICS_RLC,
    ICS_BSET,
    ICS_BCLR,
    ICS_SZ,
    ICS_SZB,
    ICS_SNZB,
    ICS_SIZ,
    ICS_SDZ,
    ICS_JMP,
    ICS_CALL,
    ICS_RET,
    ICS_INTERRUPT_RETURN,
    ICS_TBL
  } ics_op_t;

endpackage

// file: rtl/ics_alu.sv
// ics_alu: 8-bit combinational data path of the sequencer
// assumes operands are stable registers of the instruction cycle
`timescale 1ns/100ps
`default_nettype none
`include "ics_map.svh"

module ics_alu (
  // operation and operands
  input  wire ics_pkg::ics_op_t i_op,
  input  wire logic [7:0]       i_acc,
  input  wire logic [7:0]       i_opnd,
  input  wire logic             i_carry,
  input  wire logic [2:0]       i_bit_sel,
  // results
  output logic [7:0]            o_res,
  output logic                  o_carry,
  output logic                  o_carry_we,
  output logic                  o_zero_we,
  output logic                  o_skip
);

  wire [8:0] add_sum = {1'b0, i_acc} + {1'b0, i_opnd} + {8'h00, i_carry & (i_op == ics_pkg::ICS_ADC)};
  wire [8:0] sub_dif = {1'b0, i_acc} - {1'b0, i_opnd} - {8'h00, i_carry & (i_op == ics_pkg::ICS_SBC)};
  wire [7:0] bit_mask = `ICS_BYTE_ONE << i_bit_sel;
  wire [7:0] inc_val = i_opnd + `ICS_BYTE_ONE;
  wire [7:0] dec_val = i_opnd - `ICS_BYTE_ONE;

  always_comb begin
    o_res      = i_acc;
    o_carry    = i_carry;
    o_carry_we = 1'b0;
    o_zero_we  = 1'b0;
    o_skip     = 1'b0;
    unique case (i_op)
      ics_pkg::ICS_MOV_M2A, ics_pkg::ICS_MOV_I2A: o_res = i_opnd;
      ics_pkg::ICS_ADD, ics_pkg::ICS_ADC: begin
        o_res      = add_sum[7:0];
        o_carry    = add_sum[8];
        o_carry_we = 1'b1;
        o_zero_we  = 1'b1;
      end
      ics_pkg::ICS_SUB, ics_pkg::ICS_SBC: begin
        o_res      = sub_dif[7:0];
        o_carry    = sub_dif[8];
        o_carry_we = 1'b1;
        o_zero_we  = 1'b1;
      end
      ics_pkg::ICS_INC: begin
        o_res     = inc_val;
        o_zero_we = 1'b1;
      end
      ics_pkg::ICS_DEC: begin
        o_res     = dec_val;
        o_zero_we = 1'b1;
      end
      ics_pkg::ICS_AND: begin
        o_res     = i_acc & i_opnd;
        o_zero_we = 1'b1;
      end
      ics_pkg::ICS_OR: begin
        o_res     = i_acc | i_opnd;
        o_zero_we = 1'b1;
      end
      ics_pkg::ICS_XOR: begin
        o_res     = i_acc ^ i_opnd;
        o_zero_we = 1'b1;
      end
      ics_pkg::ICS_CPL: begin
        o_res     = ~i_opnd;
        o_zero_we = 1'b1;
      end
      ics_pkg::ICS_RR: o_res = {i_opnd[0], i_opnd[7:1]};
      ics_pkg::ICS_RL: o_res = {i_opnd[6:0], i_opnd[7]};
      ics_pkg::ICS_RRC: begin
        o_res      = {i_carry, i_opnd[7:1]};
        o_carry    = i_opnd[0];
        o_carry_we = 1'b1;
      end
      ics_pkg::ICS_RLC: begin
        o_res      = {i_opnd[6:0], i_carry};
        o_carry    = i_opnd[7];
        o_carry_we = 1'b1;
      end
      ics_pkg::ICS_BSET: o_res = i_opnd | bit_mask;
      ics_pkg::ICS_BCLR: o_res = i_opnd & ~bit_mask;
      ics_pkg::ICS_SZ: begin
        o_res  = i_opnd;
        o_skip = (i_opnd == `ICS_BYTE_ZERO);
      end
      ics_pkg::ICS_SZB: o_skip = ~|(i_opnd & bit_mask);
      ics_pkg::ICS_SNZB: o_skip = |(i_opnd & bit_mask);
      ics_pkg::ICS_SIZ: begin
        o_res  = inc_val;
        o_skip = (inc_val == `ICS_BYTE_ZERO);
      end
      ics_pkg::ICS_SDZ: begin
        o_res  = dec_val;
        o_skip = (dec_val == `ICS_BYTE_ZERO);
      end
      default: o_res = i_acc;
    endcase
  end

endmodule
`default_nettype wire

// file: sim/ics_sequencer_test.sv
// ics_sequencer_test: self-checking bench for the instruction cycle sequencer
// assumes the bench plays decoder and data memory; expectations come from a model
`timescale 1ns/100ps
`default_nettype none

module ics_sequencer_test;
  typedef struct packed {
    logic [7:0] r;
    logic       c;
    logic       zw;
    logic       sk;
    logic       wr;
  } ics_exp_t;

  logic             I_CLK_SYS = 1'b0;
  logic             I_RESET_N = 1'b0;
  ics_pkg::ics_op_t I_OP      = ics_pkg::ICS_NOP;
  logic             I_TO_ACC  = 1'b0;
  logic             I_USE_IMM = 1'b0;
  logic             I_DEST_PCL = 1'b0;
  logic [7:0]       I_IMM     = 8'h00;
  logic [2:0]       I_BIT_SEL = 3'h0;
  logic [7:0]       I_MEM_ADDR = 8'h00;
  logic [9:0]       I_TARGET  = 10'h000;
  logic [7:0]       I_MEM_RDATA;
  logic [7:0]       I_TBL_DATA = 8'h00;
  logic             I_GIE_CLEAR = 1'b0;
  logic [9:0]       O_FETCH_ADDR, O_TBL_ADDR;
  logic             O_CYCLE_START, O_DUMMY_CYCLE, O_MEM_WE, O_TBL_REQ;
  logic [7:0]       O_MEM_ADDR, O_MEM_WDATA, O_ACC;
  logic             O_CARRY, O_ZERO, O_GIE;
  logic [7:0]       mem [0:255];
  logic [7:0]       acc = 8'h00;
  logic             cy = 1'b0, zf = 1'b0, gie = 1'b0;
  logic [9:0]       pc = 10'h001;
  logic [9:0]       stk [$];
  int               fail_count = 0, check_count = 0;

  ics_sequencer ics_sequencer_i (.I_CLK_SYS(I_CLK_SYS), .I_RESET_N(I_RESET_N), .I_OP(I_OP),
    .I_TO_ACC(I_TO_ACC), .I_USE_IMM(I_USE_IMM), .I_DEST_PCL(I_DEST_PCL), .I_IMM(I_IMM),
    .I_BIT_SEL(I_BIT_SEL), .I_MEM_ADDR(I_MEM_ADDR), .I_TARGET(I_TARGET),
    .I_MEM_RDATA(I_MEM_RDATA), .I_TBL_DATA(I_TBL_DATA), .I_GIE_CLEAR(I_GIE_CLEAR),
    .O_FETCH_ADDR(O_FETCH_ADDR), .O_CYCLE_START(O_CYCLE_START), .O_DUMMY_CYCLE(O_DUMMY_CYCLE),
    .O_MEM_ADDR(O_MEM_ADDR), .O_MEM_WE(O_MEM_WE), .O_MEM_WDATA(O_MEM_WDATA),
    .O_TBL_ADDR(O_TBL_ADDR), .O_TBL_REQ(O_TBL_REQ), .O_ACC(O_ACC), .O_CARRY(O_CARRY),
    .O_ZERO(O_ZERO), .O_GIE(O_GIE));

  always #5 I_CLK_SYS = ~I_CLK_SYS;
  // combinational read, write lands at the edge that sees the pulse
  assign I_MEM_RDATA = mem[O_MEM_ADDR];
  always @(posedge I_CLK_SYS) if (O_MEM_WE === 1'b1) mem[O_MEM_ADDR] <= O_MEM_WDATA;

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (fail_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [19:0] seen, logic [19:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic ics_exp_t f_exp(ics_pkg::ics_op_t o, logic [7:0] a, logic [7:0] m,
                                     logic c, logic [2:0] b);
    ics_exp_t e;
    logic [8:0] s;
    logic ar;
    e = '{r: m, c: c, zw: 1'b0, sk: 1'b0, wr: 1'b1};
    s = 9'h000;
    ar = o inside {ics_pkg::ICS_ADD, ics_pkg::ICS_ADC, ics_pkg::ICS_SUB, ics_pkg::ICS_SBC};
    e.zw = ar || o inside {[ics_pkg::ICS_INC:ics_pkg::ICS_CPL]};
    case (o)
      ics_pkg::ICS_MOV_A2M: e.r = a;
      ics_pkg::ICS_ADD:  s = a + m;
      ics_pkg::ICS_ADC:  s = a + m + c;
      ics_pkg::ICS_SUB:  s = a - m;
      ics_pkg::ICS_SBC:  s = a - m - c;
      ics_pkg::ICS_INC, ics_pkg::ICS_SIZ: e.r = m + 8'h01;
      ics_pkg::ICS_DEC, ics_pkg::ICS_SDZ: e.r = m - 8'h01;
      ics_pkg::ICS_AND:  e.r = a & m;
      ics_pkg::ICS_OR:   e.r = a | m;
      ics_pkg::ICS_XOR:  e.r = a ^ m;
      ics_pkg::ICS_CPL:  e.r = ~m;
      ics_pkg::ICS_RR:   e.r = {m[0], m[7:1]};
      ics_pkg::ICS_RL:   e.r = {m[6:0], m[7]};
      ics_pkg::ICS_RRC:  e = '{r: {c, m[7:1]}, c: m[0], zw: 1'b0, sk: 1'b0, wr: 1'b1};
      ics_pkg::ICS_RLC:  e = '{r: {m[6:0], c}, c: m[7], zw: 1'b0, sk: 1'b0, wr: 1'b1};
      ics_pkg::ICS_BSET: e.r = m | (8'h01 << b);
      ics_pkg::ICS_BCLR: e.r = m & ~(8'h01 << b);
      ics_pkg::ICS_SZ:   e.sk = (m == 8'h00);
      ics_pkg::ICS_SZB:  e = '{r: m, c: c, zw: 1'b0, sk: !m[b], wr: 1'b0};
      ics_pkg::ICS_SNZB: e = '{r: m, c: c, zw: 1'b0, sk: m[b], wr: 1'b0};
      ics_pkg::ICS_MOV_M2A, ics_pkg::ICS_MOV_I2A: ;
      default: e.wr = 1'b0;
    endcase
    if (ar) begin
      e.r = s[7:0];
      e.c = s[8];
    end
    if (o inside {ics_pkg::ICS_SIZ, ics_pkg::ICS_SDZ}) e.sk = (e.r == 8'h00);
    return e;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic op(ics_pkg::ics_op_t o, logic ta, logic program_counter_low_byte, logic [7:0] a,
                    logic [7:0] imm, logic gc);
    ics_exp_t e;
    logic [7:0] m;
    logic [9:0] t, nxt;
    logic two, mw;
    int n;
    t = 10'($urandom);
    n = 0;
    while (!(O_CYCLE_START === 1'b1 && O_DUMMY_CYCLE === 1'b0) && n < 20) begin
      @(posedge I_CLK_SYS);
      #1;
      n++;
    end
    {I_OP, I_TO_ACC, I_DEST_PCL, I_MEM_ADDR, I_IMM, I_TARGET} = {o, ta, program_counter_low_byte, a, imm, t};
    I_USE_IMM = (o == ics_pkg::ICS_MOV_I2A);
    I_BIT_SEL = 3'($urandom);
    I_GIE_CLEAR = gc;
    @(posedge I_CLK_SYS);
    #1;
    I_GIE_CLEAR = 1'b0;
    m = I_USE_IMM ? imm : mem[a];
    e = f_exp(o, acc, m, cy, I_BIT_SEL);
    repeat (3) @(posedge I_CLK_SYS);
    #1;
    two = e.sk || program_counter_low_byte || o inside {[ics_pkg::ICS_JMP:ics_pkg::ICS_TBL]};
    cy = e.c;
    if (e.zw) zf = (e.r == 8'h00);
    mw = e.wr && !ta && !program_counter_low_byte && o != ics_pkg::ICS_SZ;
    if (e.wr && ta && !program_counter_low_byte) acc = e.r;
    nxt = pc + 10'h001 + 10'(e.sk);
    case (o)
      ics_pkg::ICS_JMP:  nxt = t;
      ics_pkg::ICS_CALL: begin
        stk.push_back(pc + 10'h001);
        nxt = t;
      end
      ics_pkg::ICS_RET, ics_pkg::ICS_INTERRUPT_RETURN: nxt = stk.pop_back();
      default: ;
    endcase
    if (gc) gie = 1'b0;
    if (o == ics_pkg::ICS_INTERRUPT_RETURN) gie = 1'b1;
    if (program_counter_low_byte) nxt = {pc[9:8], e.r};
    pc = nxt;
    chk("acc", O_ACC, acc);
    chk("carry", O_CARRY, cy);
    chk("zero", O_ZERO, zf);
    chk("gie", O_GIE, gie);
    chk("start", O_CYCLE_START, 1'b1);
    chk("spare", O_DUMMY_CYCLE, two);
    chk("we", O_MEM_WE, mw);
    if (mw) chk("wdata", {O_MEM_ADDR, O_MEM_WDATA}, {a, e.r});
    if (o == ics_pkg::ICS_TBL) chk("tbl", {O_TBL_REQ, O_TBL_ADDR}, {1'b1, t});
    if (two) begin
      repeat (4) @(posedge I_CLK_SYS);
      #1;
      chk("end spare", {O_DUMMY_CYCLE, O_CYCLE_START}, 2'h1);
      if (o == ics_pkg::ICS_TBL && ta) acc = I_TBL_DATA;
      if (o == ics_pkg::ICS_TBL && !ta) chk("tbl we", {O_MEM_WE, O_MEM_WDATA}, {1'b1, I_TBL_DATA});
      chk("tbl acc", O_ACC, acc);
    end
    chk("pc", O_FETCH_ADDR, pc);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    fail_count++;
    end_of_test();
  end

  initial begin
    ics_pkg::ics_op_t o;
    logic ta;
    void'($urandom(52719));
    for (int i = 0; i < 256; i++) mem[i] = 8'($urandom);
    I_TBL_DATA = 8'($urandom);
    repeat (2) @(posedge I_CLK_SYS);
    #1;
    chk("reset", {O_ACC, O_FETCH_ADDR, O_GIE, O_MEM_WE}, 20'h00000);
    I_RESET_N = 1'b1;
    // corners: carry out, borrow, skips taken and not, program counter write
    op(ics_pkg::ICS_MOV_I2A, 1'b1, 1'b0, 8'h00, 8'hff, 1'b0);
    mem[8'h20] = 8'h01;
    {mem[8'h21], mem[8'h22], mem[8'h23], mem[8'h24]} = 32'h000500ff;
    op(ics_pkg::ICS_ADD, 1'b1, 1'b0, 8'h20, 8'h00, 1'b0);
    op(ics_pkg::ICS_SUB, 1'b1, 1'b0, 8'h20, 8'h00, 1'b0);
    op(ics_pkg::ICS_SZ, 1'b0, 1'b0, 8'h21, 8'h00, 1'b0);
    op(ics_pkg::ICS_SZ, 1'b1, 1'b0, 8'h22, 8'h00, 1'b0);
    op(ics_pkg::ICS_SIZ, 1'b0, 1'b0, 8'h24, 8'h00, 1'b0);
    op(ics_pkg::ICS_SDZ, 1'b1, 1'b0, 8'h20, 8'h00, 1'b0);
    op(ics_pkg::ICS_MOV_A2M, 1'b0, 1'b1, 8'h30, 8'h00, 1'b0);
    op(ics_pkg::ICS_CALL, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0);
    op(ics_pkg::ICS_CALL, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0);
    op(ics_pkg::ICS_RET, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0);
    op(ics_pkg::ICS_INTERRUPT_RETURN, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0);
    op(ics_pkg::ICS_CALL, 1'b0, 1'b0, 8'h00, 8'h00, 1'b1);
    op(ics_pkg::ICS_RET, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0);
    op(ics_pkg::ICS_TBL, 1'b1, 1'b0, 8'h00, 8'h00, 1'b0);
    op(ics_pkg::ICS_TBL, 1'b0, 1'b0, 8'h05, 8'h00, 1'b0);
    op(ics_pkg::ICS_JMP, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0);
    // random data-path and skip classes
    for (int i = 0; i < 300; i++) begin
      o = ics_pkg::ics_op_t'(5'h01 + 5'($urandom % 24));
      ta = 1'($urandom);
      if (o inside {ics_pkg::ICS_MOV_M2A, ics_pkg::ICS_MOV_I2A}) ta = 1'b1;
      if (o inside {ics_pkg::ICS_MOV_A2M, ics_pkg::ICS_SZB, ics_pkg::ICS_SNZB}) ta = 1'b0;
      op(o, ta, o < ics_pkg::ICS_SZ && ($urandom % 16) == 0, 8'($urandom % 8),
         8'($urandom), ($urandom % 8) == 0);
    end
    end_of_test();
  end
endmodule

`default_nettype wire
